// *** shared/ftp_pkg.sv ***
// Fragment test pipeline: register map, fields, encodings.
// Assumes a 32-bit plain register port with word indices.
package ftp_pkg;
    // Register word indices
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_ORG = 4'h1;
    localparam logic [3:0] A_SIZE = 4'h2;
    localparam logic [3:0] A_COVER = 4'h3;
    localparam logic [3:0] A_ALPHA = 4'h4;
    localparam logic [3:0] A_STF = 4'h5;
    localparam logic [3:0] A_STB = 4'h6;
    localparam logic [3:0] A_STAT = 4'h7;
    // Control bits
    localparam int B_SC_EN = 0;
    localparam int B_AT_EN = 1;
    localparam int B_ST_EN = 2;
    localparam int B_MS_EN = 3;
    localparam int B_SB_ONE = 4;
    localparam int B_A2M = 5;
    localparam int B_A2ONE = 6;
    localparam int B_COV_EN = 7;
    localparam int B_FBO = 8;
    localparam int B_RGBA = 9;
    localparam int B_INT_BUF = 10;
    localparam int CTRL_W = 11;
    localparam logic [10:0] CTRL_RST = 11'h200;
    // Field positions
    localparam int F_LO = 0;
    localparam int F_HI = 16;
    localparam int F_INV = 16;
    localparam int F_FUNC = 16;
    localparam int F_MASK = 16;
    localparam int F_SFUNC = 24;
    localparam int F_SOP = 27;
    // Widths and limits
    localparam int SW = 8;
    localparam int AW = 8;
    localparam int NS = 4;
    localparam logic [7:0] V_MAX = 8'hFF;
    localparam logic [7:0] V_ZERO = 8'h00;
    localparam logic [10:0] A_QMAX = 11'h3FC;
    localparam logic [10:0] A_HALF = 11'h002;
    localparam int A_FRAC = 2;
    localparam int TH_STEP = 64;
    localparam int DITH_SH = 2;

    typedef enum logic [2:0] {
        cmp_never = 3'h0,
        cmp_always = 3'h1,
        cmp_less = 3'h2,
        cmp_less_equal = 3'h3,
        cmp_equal = 3'h4,
        cmp_greater_equal = 3'h5,
        cmp_greater = 3'h6,
        cmp_not_equal = 3'h7
    } ftp_cmp_t;

    typedef enum logic [2:0] {
        op_keep = 3'h0,
        op_zero = 3'h1,
        op_replace = 3'h2,
        op_increment_saturating = 3'h3,
        op_decrement_saturating = 3'h4,
        op_invert = 3'h5,
        op_increment_wrapping = 3'h6,
        op_decrement_wrapping = 3'h7
    } ftp_op_t;
endpackage : ftp_pkg

// *** hw/ftp_core.sv ***
// Per-fragment test stage: ownership, scissor, multisample,
// alpha compare and stencil compare, one registered stage.
// Assumes rasterizer and framebuffer ops on the same clock.
// Operation
// - Tests run in order: ownership, scissor, multisample, alpha, stencil.
// - Off-screen target: ownership always passes.
// - Scissor passes only inside left/bottom/width/height box.
// - Scissor disabled: every fragment passes it.
// - Negative width or height rejected with error flag.
// - Reset: origin 0,0, size of window or zero, disabled.
// - Multisample changes nothing unless enabled with one sample buffer.
// - Alpha-to-mask ANDs an alpha-derived mask into coverage.
// - Alpha clamped; mask bits proportional, full at max, empty at zero.
// - Mask dithered from window-relative coordinates.
// - Force-max replaces alpha with largest value.
// - Coverage override ANDs stored-value mask, optionally inverted.
// - Coverage value clamped on write and readable with invert.
// - Alpha compare only for RGBA, non-integer buffers.
// - Failing alpha compare discards; disabled always passes.
// - Reference in alpha units, fragment alpha rounded to nearest.
// - Eight compare functions.
// - Reset: alpha reference 0, always, disabled.
// - Stencil disabled: no test, no write, pass.
// - Back state for back-facing polygons, front otherwise.
// - Reference clamped; mask applied to reference and stored value.
// - Eight stencil update actions, unsigned.
// - Stencil fail: apply fail action, then discard.
// - Reset: keep actions, zero references, always, disabled.
//
// The register offsets and strobed register access are this design's own decisions.
module ftp_core #(
    parameter int WIN_W = 640,
    parameter int WIN_H = 480,
    parameter bit HAS_WIN = 1'b1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // Incoming fragment
    input wire logic frag_valid_in,
    output logic frag_ready_out,
    input wire logic [11:0] frag_x_in,
    input wire logic [11:0] frag_y_in,
    input wire logic [3:0] frag_cov_in,
    input wire logic signed [10:0] frag_alpha_in,
    input wire logic [23:0] frag_color_in,
    input wire logic frag_back_in,
    input wire logic frag_owned_in,
    input wire logic [7:0] frag_stencil_in,
    // Outgoing fragment
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [11:0] out_x_out,
    output logic [11:0] out_y_out,
    output logic [3:0] out_cov_out,
    output logic [7:0] out_alpha_out,
    output logic [23:0] out_color_out,
    output logic out_discard_out,
    output logic [7:0] out_stencil_out,
    output logic out_stencil_wr_out
);

    ////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [7:0] clamp8(
        input logic [15:0] v
    );
        logic signed [15:0] s;
        s = v;
        if (s < 0) begin
            clamp8 = ftp_pkg::V_ZERO;
        end else if (s > 16'sh00FF) begin
            clamp8 = ftp_pkg::V_MAX;
        end else begin
            clamp8 = v[7:0];
        end
    endfunction : clamp8

    function automatic logic cmp(
        input logic [2:0] f,
        input logic [7:0] a,
        input logic [7:0] b
    );
        unique case (ftp_pkg::ftp_cmp_t'(f))
            ftp_pkg::cmp_never: cmp = 1'b0;
            ftp_pkg::cmp_always: cmp = 1'b1;
            ftp_pkg::cmp_less: cmp = a < b;
            ftp_pkg::cmp_less_equal: cmp = a <= b;
            ftp_pkg::cmp_equal: cmp = a == b;
            ftp_pkg::cmp_greater_equal: cmp = a >= b;
            ftp_pkg::cmp_greater: cmp = a > b;
            ftp_pkg::cmp_not_equal: cmp = a != b;
        endcase
    endfunction : cmp

    // Thresholds k*64+d with d<64: all set at max, none at zero
    function automatic logic [3:0] cov_mask(
        input logic [7:0] a,
        input logic [5:0] d
    );
        logic [7:0] th;
        cov_mask = 4'h0;
        for (int k = 0; k < ftp_pkg::NS; k++) begin
            th = 8'(k * ftp_pkg::TH_STEP) + {2'h0, d};
            cov_mask[k] = (a != ftp_pkg::V_ZERO) && (a >= th);
        end
    endfunction : cov_mask

    function automatic logic in_span(
        input logic [11:0] c,
        input logic [15:0] lo,
        input logic [15:0] len
    );
        logic signed [17:0] cs;
        logic signed [17:0] ls;
        cs = $signed({6'h00, c});
        ls = 18'(signed'(lo));
        in_span = (cs >= ls) && (cs < ls + 18'(signed'(len)));
    endfunction : in_span

    function automatic logic [7:0] st_op(
        input logic [2:0] op,
        input logic [7:0] v,
        input logic [7:0] r
    );
        unique case (ftp_pkg::ftp_op_t'(op))
            ftp_pkg::op_keep: st_op = v;
            ftp_pkg::op_zero: st_op = ftp_pkg::V_ZERO;
            ftp_pkg::op_replace: st_op = r;
            ftp_pkg::op_increment_saturating:
                st_op = (v == ftp_pkg::V_MAX) ? v : v + 8'h01;
            ftp_pkg::op_decrement_saturating:
                st_op = (v == ftp_pkg::V_ZERO) ? v : v - 8'h01;
            ftp_pkg::op_invert: st_op = ~v;
            ftp_pkg::op_increment_wrapping: st_op = v + 8'h01;
            ftp_pkg::op_decrement_wrapping: st_op = v - 8'h01;
        endcase
    endfunction : st_op

    ////////////////////////////////////////////////////////////
    // Registers

    localparam logic [15:0] RST_W = HAS_WIN ? 16'(WIN_W) : 16'h0000;
    localparam logic [15:0] RST_H = HAS_WIN ? 16'(WIN_H) : 16'h0000;

    logic [10:0] ctrl_reg;
    logic [31:0] org_reg;
    logic [31:0] size_reg;
    logic [7:0] cov_val_reg;
    logic cov_inv_reg;
    logic [7:0] a_ref_reg;
    logic [2:0] a_func_reg;
    logic [7:0] sref_reg [2];
    logic [7:0] smask_reg [2];
    logic [2:0] sfunc_reg [2];
    logic [2:0] sop_reg [2];
    logic err_reg;
    logic [31:0] rdata_reg;

    wire wr_ctrl = reg_wr_in && reg_addr_in == ftp_pkg::A_CTRL;
    wire wr_org = reg_wr_in && reg_addr_in == ftp_pkg::A_ORG;
    wire wr_size = reg_wr_in && reg_addr_in == ftp_pkg::A_SIZE;
    wire wr_cov = reg_wr_in && reg_addr_in == ftp_pkg::A_COVER;
    wire wr_alpha = reg_wr_in && reg_addr_in == ftp_pkg::A_ALPHA;
    wire wr_stat = reg_wr_in && reg_addr_in == ftp_pkg::A_STAT;
    wire [1:0] wr_st = {reg_wr_in && reg_addr_in == ftp_pkg::A_STB,
                        reg_wr_in && reg_addr_in == ftp_pkg::A_STF};
    wire size_neg = reg_wdata_in[15] || reg_wdata_in[31];
    wire size_bad = wr_size && size_neg;
    wire [15:0] wd_lo = reg_wdata_in[15:0];
    // Error sticks; a new rejection beats a clear in the same cycle
    wire err_next = size_bad || (err_reg && !(wr_stat && reg_wdata_in[0]));

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_reg <= ftp_pkg::CTRL_RST;
            org_reg <= 32'h0000_0000;
            size_reg <= {RST_H, RST_W};
            cov_val_reg <= ftp_pkg::V_MAX;
            cov_inv_reg <= 1'b0;
            a_ref_reg <= ftp_pkg::V_ZERO;
            a_func_reg <= ftp_pkg::cmp_always;
            err_reg <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_reg <= reg_wdata_in[ftp_pkg::CTRL_W-1:0];
            if (wr_org) org_reg <= reg_wdata_in;
            if (wr_size && !size_neg) size_reg <= reg_wdata_in;
            if (wr_cov) begin
                cov_val_reg <= clamp8(wd_lo);
                cov_inv_reg <= reg_wdata_in[ftp_pkg::F_INV];
            end
            if (wr_alpha) begin
                a_ref_reg <= clamp8(wd_lo);
                a_func_reg <= reg_wdata_in[ftp_pkg::F_FUNC +: 3];
            end
            err_reg <= err_next;
        end
    end

    // Front set at index 0, back set at index 1
    for (genvar g = 0; g < 2; g++) begin : g_face
        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                sref_reg[g] <= ftp_pkg::V_ZERO;
                smask_reg[g] <= ftp_pkg::V_MAX;
                sfunc_reg[g] <= ftp_pkg::cmp_always;
                sop_reg[g] <= ftp_pkg::op_keep;
            end else if (wr_st[g]) begin
                sref_reg[g] <= clamp8(wd_lo);
                smask_reg[g] <= reg_wdata_in[ftp_pkg::F_MASK +: 8];
                sfunc_reg[g] <= reg_wdata_in[ftp_pkg::F_SFUNC +: 3];
                sop_reg[g] <= reg_wdata_in[ftp_pkg::F_SOP +: 3];
            end
        end
    end

    // Read mux; unmapped words read zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (reg_addr_in)
            ftp_pkg::A_CTRL: rd_mux = {21'h0, ctrl_reg};
            ftp_pkg::A_ORG: rd_mux = org_reg;
            ftp_pkg::A_SIZE: rd_mux = size_reg;
            ftp_pkg::A_COVER: rd_mux = {15'h0, cov_inv_reg, 8'h0, cov_val_reg};
            ftp_pkg::A_ALPHA: rd_mux = {13'h0, a_func_reg, 8'h0, a_ref_reg};
            ftp_pkg::A_STF: rd_mux = {2'h0, sop_reg[0], sfunc_reg[0],
                                      smask_reg[0], 8'h0, sref_reg[0]};
            ftp_pkg::A_STB: rd_mux = {2'h0, sop_reg[1], sfunc_reg[1],
                                      smask_reg[1], 8'h0, sref_reg[1]};
            ftp_pkg::A_STAT: rd_mux = {30'h0, out_valid_out, err_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) rdata_reg <= 32'h0000_0000;
        else if (reg_rd_in) rdata_reg <= rd_mux;
        else rdata_reg <= 32'h0000_0000;
    end
    assign reg_rdata_out = rdata_reg;

    ////////////////////////////////////////////////////////////
    // Test chain, evaluated on settings held at acceptance

    wire acc = frag_valid_in && frag_ready_out;
    assign frag_ready_out = !out_valid_out || out_ready_in;

    wire own_ok = ctrl_reg[ftp_pkg::B_FBO] || frag_owned_in;
    wire sc_in = in_span(frag_x_in, org_reg[15:0], size_reg[15:0])
        && in_span(frag_y_in, org_reg[31:16], size_reg[31:16]);
    wire sc_ok = !ctrl_reg[ftp_pkg::B_SC_EN] || sc_in;

    // Clamp then round quarter units to nearest
    wire [10:0] a_cl = frag_alpha_in < 0 ? 11'h000 :
        (frag_alpha_in > $signed(ftp_pkg::A_QMAX)) ? ftp_pkg::A_QMAX :
        frag_alpha_in;
    wire [10:0] a_rnd = (a_cl + ftp_pkg::A_HALF) >> ftp_pkg::A_FRAC;
    wire [7:0] a8 = a_rnd[7:0];

    // Dither depends on window-relative low coordinate bits only
    wire [5:0] dith = {frag_y_in[1:0], frag_x_in[1:0], 2'h0}
        ^ {frag_x_in[3:2], frag_y_in[3:2], frag_x_in[0], frag_y_in[0]};

    wire ms_act = ctrl_reg[ftp_pkg::B_MS_EN] && ctrl_reg[ftp_pkg::B_SB_ONE];
    wire a2m = ms_act && ctrl_reg[ftp_pkg::B_A2M] && !ctrl_reg[ftp_pkg::B_INT_BUF];
    wire [3:0] m_a = a2m ? cov_mask(a8, dith) : 4'hF;
    wire [3:0] m_v = cov_mask(cov_val_reg, ~dith);
    wire [3:0] m_c = (ms_act && ctrl_reg[ftp_pkg::B_COV_EN]) ?
        (cov_inv_reg ? ~m_v : m_v) : 4'hF;
    wire [3:0] cov_n = frag_cov_in & m_a & m_c;
    wire [7:0] alpha_n = (ms_act && ctrl_reg[ftp_pkg::B_A2ONE]) ?
        ftp_pkg::V_MAX : a8;

    wire at_act = ctrl_reg[ftp_pkg::B_AT_EN] && ctrl_reg[ftp_pkg::B_RGBA]
        && !ctrl_reg[ftp_pkg::B_INT_BUF];
    wire at_ok = !at_act || cmp(a_func_reg, alpha_n, a_ref_reg);

    wire face = frag_back_in;
    wire [7:0] mref = sref_reg[face] & smask_reg[face];
    wire [7:0] mval = frag_stencil_in & smask_reg[face];
    wire st_en = ctrl_reg[ftp_pkg::B_ST_EN];
    wire pre_ok = own_ok && sc_ok && at_ok;
    wire st_fail = st_en && pre_ok && !cmp(sfunc_reg[face], mref, mval);
    wire [7:0] st_new = st_op(sop_reg[face], frag_stencil_in,
        sref_reg[face]);
    wire disc_n = !pre_ok || st_fail;

    ////////////////////////////////////////////////////////////
    // Output stage

    logic valid_reg;
    logic [11:0] x_reg;
    logic [11:0] y_reg;
    logic [3:0] cov_reg;
    logic [7:0] alpha_reg;
    logic [23:0] color_reg;
    logic disc_reg;
    logic [7:0] sten_reg;
    logic swr_reg;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            valid_reg <= 1'b0;
        end else if (frag_ready_out) begin
            valid_reg <= frag_valid_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            x_reg <= 12'h000;
            y_reg <= 12'h000;
            cov_reg <= 4'h0;
            alpha_reg <= ftp_pkg::V_ZERO;
            color_reg <= 24'h000000;
            disc_reg <= 1'b0;
            sten_reg <= ftp_pkg::V_ZERO;
            swr_reg <= 1'b0;
        end else if (acc) begin
            x_reg <= frag_x_in;
            y_reg <= frag_y_in;
            cov_reg <= cov_n;
            alpha_reg <= alpha_n;
            color_reg <= frag_color_in;
            disc_reg <= disc_n;
            sten_reg <= st_fail ? st_new : frag_stencil_in;
            swr_reg <= st_fail;
        end
    end

    assign out_valid_out = valid_reg;
    assign out_x_out = x_reg;
    assign out_y_out = y_reg;
    assign out_cov_out = cov_reg;
    assign out_alpha_out = alpha_reg;
    assign out_color_out = color_reg;
    assign out_discard_out = disc_reg;
    assign out_stencil_out = sten_reg;
    assign out_stencil_wr_out = swr_reg;

    ////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_acc;
        frag_valid_in && frag_ready_out;
    endsequence
    sequence s_stall;
        out_valid_out && !out_ready_in;
    endsequence

    chk_owner_drop: assert property (
        s_acc ##0 (!ctrl_reg[ftp_pkg::B_FBO] && !frag_owned_in)
        |=> out_discard_out && !out_stencil_wr_out)
        else $error("unowned pixel not discarded");
    chk_scissor_fail: assert property (
        s_acc ##0 (ctrl_reg[ftp_pkg::B_SC_EN] && !sc_in)
        |=> out_valid_out && out_discard_out)
        else $error("scissor miss passed");
    chk_scissor_off: assert property (
        s_acc ##0 (own_ok && !ctrl_reg[ftp_pkg::B_SC_EN]
        && !ctrl_reg[ftp_pkg::B_AT_EN] && !st_en) |=> !out_discard_out)
        else $error("disabled tests discarded fragment");
    chk_size_reject: assert property (
        wr_size && size_neg |=> err_reg && $stable(size_reg))
        else $error("negative size accepted");
    chk_ms_bypass: assert property (
        s_acc ##0 !ms_act |=> out_cov_out == $past(frag_cov_in))
        else $error("coverage changed without multisample");
    chk_alpha_max: assert property (
        s_acc ##0 (ms_act && ctrl_reg[ftp_pkg::B_A2ONE])
        |=> out_alpha_out == ftp_pkg::V_MAX)
        else $error("alpha not forced to max");
    chk_stencil_off: assert property (
        s_acc ##0 !st_en |=> !out_stencil_wr_out)
        else $error("stencil written while disabled");
    chk_stencil_fail: assert property (
        s_acc ##0 st_fail |=> out_stencil_wr_out && out_discard_out
        && out_stencil_out == $past(st_new))
        else $error("stencil fail not applied");
    chk_out_hold: assert property (
        s_stall |=> out_valid_out && $stable(out_x_out)
        && $stable(out_discard_out) && $stable(out_stencil_out))
        else $error("output changed while stalled");
    chk_err_sticky: assert property (
        err_reg && !wr_stat |=> err_reg)
        else $error("error flag lost");

endmodule : ftp_core

// *** sim/ftp_fb_model.sv ***
// Downstream framebuffer-ops sink: takes finished fragments.
// Assumes one clock shared with the test stage.
module ftp_fb_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Stall control, percent of cycles not ready
    input wire logic [7:0] stall_pct_in,
    // Handshake
    output logic ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Not ready in reset so nothing is taken before release
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ready_out <= 1'b0;
        end else begin
            ready_out <= ($urandom_range(99) >= 32'(stall_pct_in));
        end
    end
endmodule : ftp_fb_model

// *** sim/testbench.sv ***
// Self-checking bench for the fragment test stage: random settings
// and fragments against a reference model. Assumes ftp_pkg and sink model.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, rst_n_in, reg_wr_in, reg_rd_in, frag_valid_in, frag_back_in, frag_owned_in;
    logic [3:0] reg_addr_in, frag_cov_in, out_cov_out;
    logic [31:0] reg_wdata_in, reg_rdata_out, rd;
    logic [11:0] frag_x_in, frag_y_in, out_x_out, out_y_out;
    logic signed [10:0] frag_alpha_in;
    logic [23:0] frag_color_in, out_color_out;
    logic [7:0] frag_stencil_in, out_alpha_out, out_stencil_out, stall;
    logic frag_ready_out, out_valid_out, out_ready_in, out_discard_out, out_stencil_wr_out;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [10:0] ctrl = 11'h200;
    logic [7:0] aref = 8'h00, cov_v = 8'hFF, sref[2] = '{8'h00, 8'h00}, smask[2] = '{8'hFF, 8'hFF};
    logic [2:0] afunc = 3'h1, sfunc[2] = '{3'h1, 3'h1}, sop[2] = '{3'h0, 3'h0};
    logic cov_inv = 1'b0;
    int l = 0, b = 0, w = 64, h = 48;
    logic [69:0] e;
    logic [69:0] expq[$];
    logic [3:0] rst_a[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
    logic [31:0] rst_v[7] = '{32'h0000_0200, 32'h0000_0000, 32'h0030_0040, 32'h0000_00FF,
        32'h0001_0000, 32'h01FF_0000, 32'h01FF_0000};

    ftp_core #(.WIN_W(64), .WIN_H(48), .HAS_WIN(1'b1)) DUT (.clk_in, .rst_n_in, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .frag_valid_in, .frag_ready_out,
        .frag_x_in, .frag_y_in, .frag_cov_in, .frag_alpha_in, .frag_color_in, .frag_back_in,
        .frag_owned_in, .frag_stencil_in, .out_valid_out, .out_ready_in, .out_x_out, .out_y_out,
        .out_cov_out, .out_alpha_out, .out_color_out, .out_discard_out, .out_stencil_out,
        .out_stencil_wr_out);
    ftp_fb_model u_fb (.clk_in, .rst_n_in, .stall_pct_in(stall), .ready_out(out_ready_in));

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_frag(input logic [69:0] got, input logic [69:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t fragment got %h exp %h", $time, got, exp);
        end
    endtask : chk_frag

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [3:0] a);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 rd = reg_rdata_out;
    endtask : rdr

    function automatic logic cmpf(input logic [2:0] fn, input logic [7:0] p, input logic [7:0] q);
        return fn == 1 || (fn == 2 && p < q) || (fn == 3 && p <= q) || (fn == 4 && p == q)
            || (fn == 5 && p >= q) || (fn == 6 && p > q) || (fn == 7 && p != q);
    endfunction : cmpf

    function automatic logic [7:0] opf(input logic [2:0] op, input logic [7:0] s, input logic [7:0] r);
        case (op)
            3'h0: return s;
            3'h1: return 8'h00;
            3'h2: return r;
            3'h3: return (s == 8'hFF) ? s : s + 8'h01;
            3'h4: return (s == 8'h00) ? s : s - 8'h01;
            3'h5: return ~s;
            3'h6: return s + 8'h01;
            default: return s - 8'h01;
        endcase
    endfunction : opf

    // Expected result of the fragment now on the inputs
    function automatic logic [69:0] exp_now();
        logic [7:0] a, sv, m;
        logic [3:0] c;
        logic d, wv, f;
        int x, y;
        f = frag_back_in;
        x = int'(frag_x_in);
        y = int'(frag_y_in);
        c = frag_cov_in;
        a = 8'((int'(frag_alpha_in) + 2) / 4);
        wv = 1'b0;
        sv = 8'h00;
        m = smask[f];
        d = !ctrl[ftp_pkg::B_FBO] && !frag_owned_in;
        if (ctrl[ftp_pkg::B_SC_EN] && !(x >= l && x < l + w && y >= b && y < b + h)) d = 1;
        if (ctrl[ftp_pkg::B_MS_EN] && ctrl[ftp_pkg::B_SB_ONE]) begin
            if (ctrl[ftp_pkg::B_A2M] && !ctrl[ftp_pkg::B_INT_BUF] && a == 8'h00) c = 4'h0;
            if (ctrl[ftp_pkg::B_A2ONE]) a = 8'hFF;
            if (ctrl[ftp_pkg::B_COV_EN] && ((cov_v == 8'hFF) == cov_inv)) c = 4'h0;
        end
        if (ctrl[ftp_pkg::B_AT_EN] && ctrl[ftp_pkg::B_RGBA] && !ctrl[ftp_pkg::B_INT_BUF]
            && !cmpf(afunc, a, aref)) d = 1;
        if (ctrl[ftp_pkg::B_ST_EN] && !d && !cmpf(sfunc[f], sref[f] & m, frag_stencil_in & m)) begin
            d = 1;
            wv = 1;
            sv = opf(sop[f], frag_stencil_in, sref[f]);
        end
        return {d, wv, sv, a, c, frag_x_in, frag_y_in, frag_color_in};
    endfunction : exp_now

    ////////////////////////////////////////////////////////////////////////
    task automatic cfg(input int r);
        ctrl = 11'($urandom());
        afunc = 3'(r);
        aref = 8'($urandom());
        cov_v = $urandom_range(1) ? 8'hFF : 8'h00;
        cov_inv = 1'($urandom());
        for (int f = 0; f < 2; f++) begin
            sref[f] = (r == 5) ? 8'hFF : 8'($urandom());
            smask[f] = 8'($urandom());
            sfunc[f] = 3'($urandom());
            sop[f] = 3'(r + f);
        end
        l = $urandom_range(31);
        b = $urandom_range(31);
        w = $urandom_range(40);
        h = $urandom_range(40);
        wr(ftp_pkg::A_ORG, {16'(b), 16'(l)});
        wr(ftp_pkg::A_SIZE, {16'(h), 16'(w)});
        wr(ftp_pkg::A_COVER, {15'h0, cov_inv, 8'h00, cov_v});
        wr(ftp_pkg::A_ALPHA, {13'h0, afunc, 8'h00, aref});
        // Out-of-range reference must act clamped in the fragment checks; it is not read back
        for (int f = 0; f < 2; f++) begin
            wr(4'(5 + f), {2'h0, sop[f], sfunc[f], smask[f], (r == 5) ? 16'h0123 : {8'h00, sref[f]}});
        end
        wr(ftp_pkg::A_CTRL, {21'h0, ctrl});
    endtask : cfg

    task automatic send(input int n);
        repeat (n) begin
            @(posedge clk_in);
            frag_valid_in <= $urandom_range(3) != 0;
            frag_x_in <= 12'($urandom_range(79));
            frag_y_in <= 12'($urandom_range(63));
            frag_cov_in <= 4'($urandom());
            frag_alpha_in <= (ctrl[ftp_pkg::B_MS_EN] && ctrl[ftp_pkg::B_SB_ONE] && ctrl[ftp_pkg::B_A2M])
                ? 11'($urandom_range(1) * 1020) : 11'($urandom_range(1020));
            frag_color_in <= 24'($urandom());
            frag_back_in <= 1'($urandom());
            frag_owned_in <= $urandom_range(7) != 0;
            frag_stencil_in <= 8'($urandom());
            @(negedge clk_in);
            while (frag_valid_in && !frag_ready_out) @(negedge clk_in);
            if (frag_valid_in) expq.push_back(exp_now());
        end
        @(posedge clk_in);
        frag_valid_in <= 1'b0;
        for (int i = 0; i < 200 && expq.size() != 0; i++) @(posedge clk_in);
        chk_word(32'(expq.size()), 32'h0000_0000);
    endtask : send

    always @(negedge clk_in) begin
        if (rst_n_in && out_valid_out && out_ready_in) begin
            e = (expq.size() != 0) ? expq.pop_front() : 70'h0;
            chk_frag({out_discard_out, out_stencil_wr_out, e[68] ? out_stencil_out : 8'h00,
                out_alpha_out, out_cov_out, out_x_out, out_y_out,
                out_color_out}, e);
        end
    end

    initial begin
        #200000;
        n_mismatch++;
        $display("MISMATCH %0t watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        {rst_n_in, reg_wr_in, reg_rd_in, frag_valid_in, frag_back_in, frag_owned_in} = 6'h00;
        {reg_addr_in, reg_wdata_in, frag_cov_in, frag_alpha_in, frag_color_in} = 75'h0;
        {frag_x_in, frag_y_in, frag_stencil_in, stall} = 40'h0;
        void'($urandom(89225));
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        foreach (rst_a[i]) begin
            rdr(rst_a[i]);
            chk_word(rd, rst_v[i]);
        end
        send(40);
        wr(ftp_pkg::A_SIZE, 32'h0010_8010);
        rdr(ftp_pkg::A_SIZE);
        chk_word(rd, 32'h0030_0040);
        rdr(ftp_pkg::A_STAT);
        chk_word(rd & 32'h0000_0001, 32'h0000_0001);
        wr(ftp_pkg::A_STAT, 32'h0000_0001);
        wr(4'hF, 32'hFFFF_FFFF);
        rdr(ftp_pkg::A_STAT);
        chk_word(rd & 32'h0000_0001, 32'h0000_0000);
        rdr(ftp_pkg::A_CTRL);
        chk_word(rd, 32'h0000_0200);
        wr(ftp_pkg::A_COVER, 32'h0001_FF00);
        rdr(ftp_pkg::A_COVER);
        chk_word(rd, 32'h0001_0000);
        wr(ftp_pkg::A_COVER, 32'h0000_0300);
        rdr(ftp_pkg::A_COVER);
        chk_word(rd, 32'h0000_00FF);
        for (int r = 0; r < 16; r++) begin
            cfg(r);
            stall <= r[0] ? 8'h32 : 8'h00;
            send(40);
        end
        tally_and_finish();
    end
endmodule : testbench
